// [design/sss_pkg.sv]
// sss_pkg: constants, states and carriers of the shading scan sequencer.
// assumes a single 200 MHz clock and a line-rate trigger pulse.
// Behaviour
// - three-input colour white detect ends after 17 lines
// - each channel run 17 lines, busy shows progress
// - one-input colour detects all colours, 49 lines
// - one-input monochrome forces input channel zero
// - monochrome detect ends 17 lines, fixed bank for one-input only
// - averaging count N repeats detection N+1 times
// - averaging count zero stores single pass directly
// - three-bit channel enable mask, one enables
// - offset mode two and peak enable all
// - one-input colour detection ignores the mask
// - detection stores only the enabled channel
// - pixel black correction subtracts shading plus adjust
// - offset cancel subtracts even or odd offset
// - white output is pixel*2555/(1022+3*white)
// - three-input samples together, outputs in order
// - disabled channel: no strobe, clock, bus low
// - one-input scanning starts one line after command
// - run pin stops and restarts one-input scanning
// - disabled colour produces no video or clock
// - sixteen passes, pass m captures 16n+m
package sss_pkg;
    localparam int          PASSES        = 16;
    localparam int          SETTLE_LINES  = 1;
    localparam logic [1:0]  MONO_BANK     = 2'h0;
    localparam logic [2:0]  MASK_RESET    = 3'h7;
    localparam logic [5:0]  ORDER_RESET   = 6'h24;
    localparam logic [11:0] WHITE_NUM     = 12'h9fb;
    localparam logic [11:0] WHITE_BASE    = 12'h3fe;
    localparam logic [9:0]  VIDEO_MAX     = 10'h3ff;

    typedef enum logic [2:0] {
        SSS_CMD_IDLE    = 3'b000,
        SSS_CMD_WHITE   = 3'b001,
        SSS_CMD_BLACK   = 3'b010,
        SSS_CMD_OFFCAL2 = 3'b011,
        SSS_CMD_PEAK    = 3'b100,
        SSS_CMD_SCAN    = 3'b101
    } sss_cmd_t;

    typedef enum logic [2:0] {
        SSS_ST_IDLE     = 3'b000,
        SSS_ST_DET_WAIT = 3'b001,
        SSS_ST_DET_RUN  = 3'b010,
        SSS_ST_SCN_WAIT = 3'b011,
        SSS_ST_SCAN     = 3'b100
    } sss_state_t;

    typedef struct packed {
        logic [9:0] ch2;
        logic [9:0] ch1;
        logic [9:0] ch0;
    } sss_samples_t;

    typedef struct packed {
        logic [2:0][9:0] black;
        logic [2:0][8:0] white;
        logic [2:0][9:0] even_off;
        logic [2:0][9:0] odd_off;
        logic [2:0][9:0] adjust;
        logic [2:0]      adjust_neg;
    } sss_shading_t;
endpackage : sss_pkg

// [design/sss_top.sv]
// sss_top: shading detection and document scan sequencer.
// assumes trig and pixel_valid are one-cycle pulses in the clk domain and
// pixel_valid pulses are at least three cycles apart.
`timescale 1ns/10ps
module sss_top import sss_pkg::*; #(
    parameter int AVG_W = 4
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // host command and configuration
    input  wire logic              cmd_valid,
    input  wire sss_cmd_t          cmd_code,
    input  wire logic              mask_wr,
    input  wire logic [2:0]        mask_data,
    input  wire logic              order_wr,
    input  wire logic [5:0]        order_data,
    input  wire logic [AVG_W-1:0]  averaging_count_reg,
    input  wire logic              three_input,
    input  wire logic              color_mode,
    input  wire logic              offset_cancel,
    output logic                   busy_bit,
    // line pacing and sensor data
    input  wire logic              trig,
    input  wire logic              proc_run_pin,
    input  wire logic              pixel_valid,
    input  wire sss_samples_t      samples,
    input  wire sss_shading_t      shading,
    // shading capture port
    output logic                   det_capture,
    output logic [1:0]             det_bank,
    output logic [3:0]             det_pass,
    output logic [9:0]             det_data,
    output logic                   det_store,
    // video port
    output logic [9:0]             video_out_bus,
    output logic                   ch0_data_strobe,
    output logic                   ch1_data_strobe,
    output logic                   ch2_data_strobe,
    output logic                   video_sample_clock
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [9:0] black_corr(input logic [9:0] pix,
                                              input logic [9:0] base,
                                              input logic [9:0] adj,
                                              input logic       neg);
        logic [11:0] sub;
        sub = neg ? {2'h0, base} - {2'h0, adj} : {2'h0, base} + {2'h0, adj};
        if (sub[11])
            sub = 12'h0;
        black_corr = ({2'h0, pix} > sub) ? 10'(({2'h0, pix} - sub)) : 10'h0;
    endfunction : black_corr

    function automatic logic [9:0] white_corr(input logic [9:0] bc,
                                              input logic [8:0] w);
        logic [21:0] num;
        logic [11:0] den;
        logic [21:0] q;
        num = 22'(bc) * 22'(WHITE_NUM);
        den = WHITE_BASE + 12'(w) * 12'h3;
        q   = num / 22'(den);
        white_corr = (q > 22'(VIDEO_MAX)) ? VIDEO_MAX : q[9:0];
    endfunction : white_corr

    ////////////////////////////////////////////////////////////////////////
    sss_state_t      state;
    sss_state_t      next_state;
    sss_cmd_t        mode;
    logic [2:0]      mask;
    logic [5:0]      order;
    logic [5:0]      line;
    logic [AVG_W-1:0] rep;
    logic [AVG_W-1:0] avg_n;
    logic [12:0]     pix_idx;
    logic [1:0]      slot;
    logic            slot_busy;
    logic [1:0]      color_slot;
    logic            run_d;
    sss_samples_t    held;
    logic [2:0]      eff_mask;
    logic [5:0]      last_line;
    logic            one_color;
    logic            mono_one;

    assign one_color = !three_input && color_mode;
    assign mono_one  = !three_input && !color_mode;
    // a one-input colour run walks three colours of sixteen passes each
    assign last_line = one_color ? 6'(PASSES * 3)
                                 : 6'(PASSES);

    always_comb begin
        if (mode == SSS_CMD_OFFCAL2 || mode == SSS_CMD_PEAK)
            eff_mask = 3'h7;
        else if (mono_one)
            eff_mask = 3'h1;
        else if (one_color && (mode == SSS_CMD_WHITE ||
                               mode == SSS_CMD_BLACK))
            eff_mask = 3'h7;
        else
            eff_mask = mask;
    end

    ////////////////////////////////////////////////////////////////////////
    // write-only registers; the mask is left all-enabled so scanning works
    always_ff @(posedge clk) begin
        if (reset) begin
            mask  <= MASK_RESET;
            order <= ORDER_RESET;
        end else begin
            if (mask_wr)
                mask <= mask_data;
            if (order_wr)
                order <= order_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        unique case (state)
            SSS_ST_IDLE: begin
                if (cmd_valid && cmd_code == SSS_CMD_SCAN)
                    next_state = SSS_ST_SCN_WAIT;
                else if (cmd_valid && cmd_code != SSS_CMD_IDLE)
                    next_state = SSS_ST_DET_WAIT;
            end
            // command latency: the run starts on the next line boundary
            SSS_ST_DET_WAIT: begin
                if (trig)
                    next_state = SSS_ST_DET_RUN;
            end
            SSS_ST_DET_RUN: begin
                if (trig && line == last_line && rep == avg_n)
                    next_state = SSS_ST_IDLE;
            end
            SSS_ST_SCN_WAIT: begin
                if (trig)
                    next_state = SSS_ST_SCAN;
            end
            SSS_ST_SCAN: begin
                if (cmd_valid && cmd_code == SSS_CMD_IDLE)
                    next_state = SSS_ST_IDLE;
            end
            default: next_state = SSS_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state    <= SSS_ST_IDLE;
            busy_bit <= 1'b0;
        end else begin
            state    <= next_state;
            busy_bit <= next_state != SSS_ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode  <= SSS_CMD_IDLE;
            avg_n <= '0;
        end else if (state == SSS_ST_IDLE && cmd_valid) begin
            mode  <= cmd_code;
            avg_n <= averaging_count_reg;
        end
    end

    // line counter: line 0 settles, lines 1..last are capture passes
    always_ff @(posedge clk) begin
        if (reset) begin
            line <= '0;
            rep  <= '0;
        end else if (state != SSS_ST_DET_RUN) begin
            line <= '0;
            rep  <= '0;
        end else if (trig) begin
            if (line == last_line) begin
                line <= '0;
                rep  <= rep + 1'b1;
            end else begin
                line <= line + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset)
            pix_idx <= '0;
        else if (trig)
            pix_idx <= '0;
        else if (pixel_valid)
            pix_idx <= pix_idx + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // shading capture: pass m of a colour takes pixels 16n+m
    logic [5:0] pass_line;
    logic [1:0] det_color;
    logic [1:0] det_ch;
    assign pass_line = line - 6'(SETTLE_LINES);
    assign det_color = one_color ? 2'(pass_line / 6'(PASSES)) : 2'h0;
    always_comb begin
        if (one_color)
            det_ch = order[2*det_color +: 2];
        else if (eff_mask[2])
            det_ch = 2'h2;
        else if (eff_mask[1])
            det_ch = 2'h1;
        else
            det_ch = 2'h0;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            det_capture <= 1'b0;
            det_bank    <= '0;
            det_pass    <= '0;
            det_data    <= '0;
            det_store   <= 1'b0;
        end else begin
            det_capture <= state == SSS_ST_DET_RUN && line != 6'h0
                && pixel_valid && mode == SSS_CMD_WHITE
                && pix_idx[3:0] == pass_line[3:0]
                && eff_mask[det_ch];
            det_pass    <= pass_line[3:0];
            det_bank    <= mono_one ? MONO_BANK : det_ch;
            det_data    <= (mono_one || one_color) ? samples.ch0
                         : samples[10*det_ch +: 10];
            // only the final repetition carries the averaged result
            det_store   <= rep == avg_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scan path: three-input samples are held and sent in three slots in colour, one slot in monochrome
    always_ff @(posedge clk) begin
        if (reset) begin
            held      <= '0;
            slot      <= '0;
            slot_busy <= 1'b0;
        end else if (state == SSS_ST_SCAN && pixel_valid) begin
            held      <= samples;
            slot      <= '0;
            slot_busy <= 1'b1;
        end else if (slot_busy) begin
            slot      <= slot + 1'b1;
            slot_busy <= three_input && color_mode && slot != 2'h2;
        end
    end

    // one-input colour: colour per line; a stopped run restarts at slot 0
    always_ff @(posedge clk) begin
        if (reset) begin
            color_slot <= '0;
            run_d      <= 1'b0;
        end else begin
            run_d <= proc_run_pin;
            if (state != SSS_ST_SCAN || (proc_run_pin && !run_d))
                color_slot <= '0;
            else if (trig && proc_run_pin)
                color_slot <= (color_slot == 2'h2) ? 2'h0
                            : color_slot + 1'b1;
        end
    end

    logic [1:0] out_ch;
    logic [9:0] out_pix;
    logic       out_go;
    logic [9:0] bc;
    always_comb begin
        if (three_input && color_mode) begin
            out_ch = order[2*slot +: 2];
            out_go = slot_busy;
        end else if (one_color) begin
            out_ch = order[2*color_slot +: 2];
            out_go = state == SSS_ST_SCAN && pixel_valid && proc_run_pin;
        end else if (three_input) begin
            out_ch = eff_mask[2] ? 2'h2 : (eff_mask[1] ? 2'h1 : 2'h0);
            out_go = slot_busy;
        end else begin
            out_ch = 2'h0;
            out_go = state == SSS_ST_SCAN && pixel_valid && proc_run_pin;
        end
        out_pix = three_input ? held[10*out_ch +: 10] : samples.ch0;
        if (!offset_cancel)
            bc = black_corr(out_pix, shading.black[out_ch],
                 shading.adjust[out_ch], shading.adjust_neg[out_ch]);
        else if (pix_idx[0] ^ three_input)  // held pixel: index moved on
            bc = black_corr(out_pix, shading.odd_off[out_ch],
                 shading.adjust[out_ch], shading.adjust_neg[out_ch]);
        else
            bc = black_corr(out_pix, shading.even_off[out_ch],
                 shading.adjust[out_ch], shading.adjust_neg[out_ch]);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            video_out_bus      <= '0;
            ch0_data_strobe    <= 1'b0;
            ch1_data_strobe    <= 1'b0;
            ch2_data_strobe    <= 1'b0;
            video_sample_clock <= 1'b0;
        end else if (out_go && eff_mask[out_ch]) begin
            video_out_bus      <= white_corr(bc,
                                  shading.white[out_ch]);
            ch0_data_strobe    <= out_ch == 2'h0;
            ch1_data_strobe    <= out_ch == 2'h1;
            ch2_data_strobe    <= out_ch == 2'h2;
            video_sample_clock <= 1'b1;
        end else begin
            video_out_bus      <= '0;
            ch0_data_strobe    <= 1'b0;
            ch1_data_strobe    <= 1'b0;
            ch2_data_strobe    <= 1'b0;
            video_sample_clock <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [9:0] run_lines;
    always_ff @(posedge clk) begin
        if (reset || state != SSS_ST_DET_RUN)
            run_lines <= '0;
        else if (trig)
            run_lines <= run_lines + 1'b1;
    end

    a_busy_state: assert property (@(posedge clk) disable iff (reset)
        $fell(busy_bit) |-> $past(trig) || $past(cmd_valid))
        else $error("busy fell away from a line start or stop command");
    a_cmd_busy: assert property (@(posedge clk) disable iff (reset)
        state == SSS_ST_IDLE && cmd_valid && cmd_code != SSS_CMD_IDLE
        |=> busy_bit)
        else $error("accepted command did not raise busy");
    a_run_length: assert property (@(posedge clk) disable iff (reset)
        state == SSS_ST_DET_RUN && next_state == SSS_ST_IDLE
        |-> run_lines + 10'h1 == (10'(last_line) + 10'h1)
            * (10'(avg_n) + 10'h1))
        else $error("detection run length wrong");
    a_mono_ch0: assert property (@(posedge clk) disable iff (reset)
        mono_one && state == SSS_ST_SCAN
        |=> !ch1_data_strobe && !ch2_data_strobe)
        else $error("monochrome output left input channel zero");
    a_quiet_slot: assert property (@(posedge clk) disable iff (reset)
        !video_sample_clock |-> video_out_bus == 10'h0
            && !ch0_data_strobe && !ch1_data_strobe && !ch2_data_strobe)
        else $error("disabled slot shows data or strobe");
    a_mask_gate: assert property (@(posedge clk) disable iff (reset)
        out_go && !eff_mask[out_ch] |=> !video_sample_clock)
        else $error("disabled colour produced a sample clock");
    a_pass_pos: assert property (@(posedge clk) disable iff (reset)
        det_capture |-> $past(pix_idx[3:0]) == det_pass)
        else $error("capture at wrong pixel position");
    a_scan_delay: assert property (@(posedge clk) disable iff (reset)
        state == SSS_ST_IDLE && cmd_valid && cmd_code == SSS_CMD_SCAN
        ##1 !trig [*2] |-> state == SSS_ST_SCN_WAIT)
        else $error("scanning began before a line boundary");
endmodule : sss_top

// [tb/sss_line_src.sv]
// sss_line_src: line and pixel pacer standing in for the sensor side.
// assumes the bench holds reset first; drives on falling clock edges.
`timescale 1ns/10ps
module sss_line_src import sss_pkg::*; #(
    parameter int LINE_PIX = 32
) (
    // clock and reset
    input  wire logic    clk,
    input  wire logic    reset,
    // line pacing and sensor data
    output logic         trig,
    output logic         pixel_valid,
    output sss_samples_t samples
);
    int seed = 32'h9da1;
    int gap;

    function automatic logic [9:0] pick();
        return 10'(200 + $unsigned($random(seed)) % 501);
    endfunction : pick

    ////////////////////////////////////////////////////////////
    // samples change every cycle: nothing is held past the pulse
    always @(negedge clk) begin
        samples <= {pick(), pick(), pick()};
    end

    // trig never stops; pixel spacing wanders from 4 to 6 cycles
    initial begin
        trig = 1'b0;
        pixel_valid = 1'b0;
        samples = '0;
        @(negedge reset);
        forever begin
            @(negedge clk);
            trig <= 1'b1;
            @(negedge clk);
            trig <= 1'b0;
            repeat (4) @(negedge clk);
            for (int p = 0; p < LINE_PIX; p++) begin
                pixel_valid <= 1'b1;
                @(negedge clk);
                pixel_valid <= 1'b0;
                gap = 3 + $unsigned($random(seed)) % 3;
                repeat (gap) @(negedge clk);
            end
        end
    end
endmodule : sss_line_src

// [tb/test_shading_scan_sequencer.sv]
// test_shading_scan_sequencer: bench with a cycle model of the sequencer.
// assumes sss_line_src paces lines of 32 pixels at the 200 MHz clock.
`timescale 1ns/10ps
module test_shading_scan_sequencer
    import sss_pkg::*;
;
    logic clk, reset, cmd_valid, mask_wr, order_wr, three_input, color_mode;
    logic offset_cancel, proc_run_pin, trig, pixel_valid, busy_bit;
    logic det_capture, det_store, video_sample_clock;
    logic ch0_data_strobe, ch1_data_strobe, ch2_data_strobe;
    sss_cmd_t     cmd_code;
    logic [2:0]   mask_data, strobes, mask_m;
    logic [5:0]   order_data, order_m;
    logic [3:0]   averaging_count_reg, det_pass;
    logic [1:0]   det_bank;
    logic [9:0]   det_data, video_out_bus;
    sss_samples_t samples;
    sss_shading_t shading;
    int           bad_count = 0, compares = 0, seed = 32'h9da1;
    int           mode, lines, pix, cidx, total, len, navg, ec, k, ch, lr, ps;
    logic         three, col, run_prev;
    logic [2:0]   r_str [8];
    logic [9:0]   r_vid [8], r_dat [8];
    logic [3:0]   r_pass [8];
    logic [1:0]   r_bank [8];
    logic         r_vclk [8], r_cap [8], r_store [8];
    logic [2:0]   masks [3] = '{3'h7, 3'h3, 3'h5};
    logic [5:0]   orders [3] = '{6'h24, 6'h12, 6'h09};

    assign strobes = {ch2_data_strobe, ch1_data_strobe, ch0_data_strobe};

    sss_top u_dut (
        .clk, .reset, .cmd_valid, .cmd_code, .mask_wr, .mask_data, .order_wr,
        .order_data, .averaging_count_reg, .three_input, .color_mode,
        .offset_cancel, .busy_bit, .trig, .proc_run_pin, .pixel_valid,
        .samples, .shading, .det_capture, .det_bank, .det_pass, .det_data,
        .det_store, .video_out_bus, .ch0_data_strobe, .ch1_data_strobe,
        .ch2_data_strobe, .video_sample_clock
    );
    sss_line_src u_src (.clk, .reset, .trig, .pixel_valid, .samples);

    ////////////////////////////////////////////////////////////
    task automatic chk_flag(logic a, logic e);
        compares++;
        if (a !== e) begin
            bad_count++;
            $display("unexpected t=%0t got %h exp %h", $time, a, e);
        end
    endtask : chk_flag

    task automatic chk_val(logic [9:0] a, logic [9:0] e);
        compares++;
        if (a !== e) begin
            bad_count++;
            $display("unexpected t=%0t got %h exp %h", $time, a, e);
        end
    endtask : chk_val

    function automatic logic [9:0] corr(int c, int sv, int idx);
        int base, adj, b;
        base = offset_cancel ? ((idx % 2 == 0) ? shading.even_off[c]
                                               : shading.odd_off[c])
                             : shading.black[c];
        adj = shading.adjust[c];
        // a negative black level corrects nothing; results floor at zero
        adj = shading.adjust_neg[c] ? base - adj : base + adj;
        b = sv - (adj < 0 ? 0 : adj);
        b = b < 0 ? 0 : b;
        return 10'(b * 2555 / (1022 + 3 * shading.white[c]));
    endfunction : corr

    function automatic void put(int s, int c, int sv, logic gate);
        if (!gate || mask_m[c]) begin
            r_str[s%8][c] = 1'b1;
            r_vclk[s%8] = 1'b1;
            r_vid[s%8] = corr(c, sv, pix);
        end
    endfunction : put

    function automatic void clear(int i);
        r_str[i] = 3'h0;
        r_vid[i] = 10'h000;
        r_pass[i] = 4'h0;
        r_vclk[i] = 1'b0;
        r_cap[i] = 1'b0;
        r_store[i] = 1'b0;
        r_bank[i] = 2'h0;
        r_dat[i] = 10'h000;
    endfunction : clear

    // model reads pre-edge values, so it never races the design's updates
    always @(posedge clk) begin
        if (reset) begin
            mode = 0;
            ec = 0;
            run_prev = 1'b1;
            mask_m = MASK_RESET;
            order_m = ORDER_RESET;
            for (int i = 0; i < 8; i++) clear(i);
        end else begin
            k = ec % 8;
            chk_flag(busy_bit, mode != 0);
            chk_flag(det_capture, r_cap[k]);
            chk_flag(video_sample_clock, r_vclk[k]);
            chk_val(10'(strobes), 10'(r_str[k]));
            chk_val(video_out_bus, r_vid[k]);
            if (r_cap[k]) begin
                chk_val(10'(det_pass), 10'(r_pass[k]));
                chk_flag(det_store, r_store[k]);
            end
            if (r_cap[k]) begin
                chk_val(10'(det_bank), 10'(r_bank[k]));
                chk_val(det_data, r_dat[k]);
            end
            clear(k);
            if (mask_wr) mask_m = mask_data;
            if (order_wr) order_m = order_data;
            if (cmd_valid && mode == 0
                && cmd_code inside {SSS_CMD_WHITE, SSS_CMD_SCAN}) begin
                mode = (cmd_code == SSS_CMD_WHITE) ? 1 : 2;
                // a line start on the taking edge is not yet the run's
                lines = trig ? -2 : -1;
                cidx = 0;
                three = three_input;
                col = color_mode;
                navg = averaging_count_reg;
                len = (three || !col) ? 17 : 49;
                total = len * (navg + 1);
            end else if (cmd_valid && mode == 2
                         && cmd_code == SSS_CMD_IDLE) begin
                mode = 0;
            end
            if (proc_run_pin && !run_prev) cidx = 0;
            run_prev = proc_run_pin;
            if (trig) begin
                pix = 0;
                lines++;
                if (mode == 1 && lines == total) mode = 0;
                if (mode == 2 && lines > 0 && proc_run_pin)
                    cidx = (cidx + 1) % 3;
            end
            if (pixel_valid && mode == 1 && lines >= 0) begin
                lr = lines % len;
                ps = (lr - 1) % 16;
                if (lr > 0 && pix % 16 == ps) begin
                    r_cap[(k+1)%8] = 1'b1;
                    r_pass[(k+1)%8] = 4'(ps);
                    r_store[(k+1)%8] = (lines / len == navg);
                    ch = three ? (mask_m[2] ? 2 : (mask_m[1] ? 1 : 0))
                       : (col ? order_m[2*((lr-1)/16) +: 2] : MONO_BANK);
                    r_bank[(k+1)%8] = 2'(ch);
                    r_dat[(k+1)%8] = three ? samples[10*ch +: 10] : samples.ch0;
                end
            end
            if (pixel_valid && mode == 2 && lines >= 0 && three) begin
                for (int t = 0; t < 3; t++) begin
                    ch = order_m[2*t +: 2];
                    put(k + 2 + t, ch, samples[10*ch +: 10], 1'b1);
                end
            end
            if (pixel_valid && mode == 2 && lines >= 0 && !three
                && proc_run_pin) begin
                ch = col ? order_m[2*cidx +: 2] : 0;
                put(k + 1, ch, samples.ch0, col);
            end
            if (pixel_valid) pix++;
            ec++;
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic pulse_cmd(sss_cmd_t c);
        @(negedge clk);
        cmd_code = c;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask : pulse_cmd

    task automatic set_cfg(logic [2:0] m, logic [5:0] o);
        @(negedge clk);
        mask_data = m;
        order_data = o;
        mask_wr = 1'b1;
        order_wr = 1'b1;
        @(negedge clk);
        mask_wr = 1'b0;
        order_wr = 1'b0;
    endtask : set_cfg

    task automatic wait_lines(int n);
        repeat (n) @(posedge trig);
    endtask : wait_lines

    task automatic wait_idle(int n);
        for (int c = 0; c < n * 210 && busy_bit !== 1'b0; c++) @(negedge clk);
        chk_flag(busy_bit, 1'b0);
    endtask : wait_idle

    task automatic new_shading();
        for (int c = 0; c < 3; c++) begin
            shading.black[c] = 10'($unsigned($random(seed)) % 100);
            shading.even_off[c] = 10'($unsigned($random(seed)) % 100);
            shading.odd_off[c] = 10'($unsigned($random(seed)) % 100);
            shading.adjust[c] = 10'($unsigned($random(seed)) % 50);
            shading.adjust_neg[c] = 1'($random(seed));
            shading.white[c] = 9'(300 + $unsigned($random(seed)) % 212);
        end
    endtask : new_shading

    // a scan command is refused mid-run, so the run length must not change
    task automatic detect(logic thr, logic cl, logic [2:0] m, int n, int lim);
        three_input = thr;
        color_mode = cl;
        averaging_count_reg = 4'(n);
        set_cfg(m, 6'h24);
        pulse_cmd(SSS_CMD_WHITE);
        wait_lines(3);
        pulse_cmd(SSS_CMD_SCAN);
        wait_idle(lim);
    endtask : detect

    task automatic scan(logic wr, logic thr, logic cl, logic [2:0] m,
                        logic [5:0] o, logic oc, int n);
        three_input = thr;
        color_mode = cl;
        offset_cancel = oc;
        new_shading();
        if (wr) set_cfg(m, o);
        pulse_cmd(SSS_CMD_SCAN);
        wait_lines(n);
        pulse_cmd(SSS_CMD_IDLE);
        wait_idle(2);
    endtask : scan

    task automatic report_and_stop();
        if (bad_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        reset = 1'b1;
        cmd_valid = 1'b0;
        cmd_code = SSS_CMD_IDLE;
        mask_wr = 1'b0;
        mask_data = 3'h0;
        order_wr = 1'b0;
        order_data = 6'h00;
        averaging_count_reg = 4'h0;
        three_input = 1'b1;
        color_mode = 1'b1;
        offset_cancel = 1'b0;
        proc_run_pin = 1'b1;
        shading = '0;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        scan(0, 1, 1, 3'h0, 6'h00, 0, 2);
        for (int i = 0; i < 3; i++) scan(1, 1, 1, masks[i], orders[i], i[0], 3);
        detect(1, 1, 3'h1, 0, 19);
        detect(1, 1, 3'h4, 1, 37);
        detect(0, 1, 3'h1, 0, 51);
        detect(0, 0, 3'h2, 2, 53);
        scan(1, 0, 0, 3'h2, 6'h24, 1, 2);
        scan(1, 0, 1, 3'h5, 6'h24, 0, 4);
        pulse_cmd(SSS_CMD_SCAN);
        wait_lines(2);
        proc_run_pin = 1'b0;
        wait_lines(2);
        set_cfg(3'h5, 6'h12);
        proc_run_pin = 1'b1;
        wait_lines(4);
        pulse_cmd(SSS_CMD_IDLE);
        wait_idle(2);
        report_and_stop();
    end
endmodule : test_shading_scan_sequencer
